// [hw/acf_pkg.sv]
package acf_pkg;

   // ***************************************************************
   // configuration word layout
   // ***************************************************************
   localparam int CFG_W = 12;
   localparam int ACQ_HI = 11;
   localparam int ACQ_LO = 10;
   localparam int OS_HI = 9;
   localparam int OS_LO = 6;
   localparam int INT_HI = 5;
   localparam int INT_LO = 2;
   localparam int RANGE_BIT = 1;
   localparam int FMT_BIT = 0;
   localparam logic [11:0] CFG_RESET = 12'h000;
   localparam logic [3:0] CFG_LAST_BIT = 4'hb;

   // ***************************************************************
   // acquisition codes and clock counts
   // ***************************************************************
   localparam logic [1:0] ACQ_NO_CORR = 2'h0;
   localparam logic [1:0] ACQ_ONE = 2'h1;
   localparam logic [1:0] ACQ_SIXTEEN = 2'h2;
   localparam logic [1:0] ACQ_THIRTYTWO = 2'h3;
   localparam logic [4:0] ACQ_CLK_ZERO = 5'h00;
   localparam logic [4:0] ACQ_CLK_MID = 5'h0f;
   localparam logic [4:0] ACQ_CLK_LONG = 5'h1f;
   localparam logic [1:0] RESET_CLOCKS = 2'h1;

   // ***************************************************************
   // counts and result coding
   // ***************************************************************
   localparam logic [8:0] COUNT_MAX = 9'h100;
   localparam logic [8:0] COUNT_ONE = 9'h001;
   localparam logic [4:0] EXP_MAX = 5'h08;
   localparam int RES_W = 21;
   localparam logic [4:0] LEN_TWOS = 5'h15;
   localparam logic [4:0] LEN_STRAIGHT = 5'h14;
   localparam logic [20:0] UNI_STRAIGHT_OFFSET = 21'h001000;
   localparam logic [20:0] BIP_OFFSET = 21'h080000;
   localparam logic [20:0] NO_OFFSET = 21'h000000;

   // top bit set means the largest count
   function automatic logic [8:0] acf_pow_count(input logic [3:0] code);
      acf_pow_count = code[3] ? COUNT_MAX : (COUNT_ONE << code[2:0]);
   endfunction : acf_pow_count

   function automatic logic [4:0] acf_exp(input logic [3:0] code);
      acf_exp = code[3] ? EXP_MAX : {2'h0, code[2:0]};
   endfunction : acf_exp

   typedef struct packed {
      logic [2:0] meta;
      logic [2:0] sync;
      logic [3:0] bit_cnt;
      logic [11:0] cfg_shift;
      logic [11:0] config_word;
      logic [4:0] acq_clocks;
      logic corr;
      logic [8:0] os_count;
      logic [8:0] init_samples;
      logic [8:0] integ_count;
      logic bipolar;
      logic twos;
      logic conflict;
      logic [20:0] result_word;
      logic [20:0] out_sr;
      logic [4:0] result_len;
      logic [4:0] bits_left;
      logic data_valid;
   } acf_state_t;

endpackage : acf_pkg

// [hw/acf_result_coder.sv]
`timescale 1ns/1ps
module acf_result_coder #(
   parameter int RES_W = 21
) (
   // converter value, signed lsb counts around zero input
   input wire logic signed [RES_W-1:0] raw_value,
   // format selection
   input wire logic bipolar_range,
   input wire logic correlated_double_sampling,
   input wire logic twos_complement_format,
   // coded result, right aligned
   output logic [RES_W-1:0] code,
   output logic [4:0] code_len
);

   logic [RES_W-1:0] offset;
   logic [RES_W-1:0] sum;

   generate
      if (RES_W != acf_pkg::RES_W) begin : g_bad_width
         $error("acf_result_coder: result width must match the coded format");
      end
   endgenerate

   always_comb begin
      // same mapping for unipolar with or without correlation
      if (!bipolar_range) begin
         offset = twos_complement_format ? acf_pkg::NO_OFFSET
                                         : acf_pkg::UNI_STRAIGHT_OFFSET;
      end else if (twos_complement_format && correlated_double_sampling) begin
         offset = acf_pkg::NO_OFFSET;
      end else begin
         offset = acf_pkg::BIP_OFFSET;
      end
      sum = raw_value + offset;
      if (twos_complement_format) begin
         code = sum;
         code_len = acf_pkg::LEN_TWOS;
      end else begin
         // straight binary drops the sign position
         code = {1'b0, sum[RES_W-2:0]};
         code_len = acf_pkg::LEN_STRAIGHT;
      end
   end

endmodule : acf_result_coder

// [hw/acf_setup_format.sv]
`timescale 1ns/1ps
// Function
// - oversample code 0-7 gives 1..128 samples, top bit set gives 256.
// - same oversample count used for initial and final data points; code 00 takes no initial point.
// - integration code 0-7 gives 1..128 integrations, top bit set gives 256.
// - acquisition code 00: one reset clock, no acquisition, no correlation.
// - codes 01, 10, 11 give 0, 15, 31 acquisition clocks after reset.
// - range bit 1 bipolar; format bit 1 two's complement.
// - two's complement result is 21 bits, sign sent first.
// - unipolar two's complement: zero is all zeros.
// - unipolar straight binary 20 bits, zero at 0x01000.
// - unipolar mapping independent of correlated sampling.
// - bipolar two's complement uncorrelated: zero at 0x80000.
// - bipolar two's complement correlated: zero is all zeros.
// - bipolar straight binary is offset binary, zero at 0x80000.
// - twelve bit word: acquisition, oversample, integration, range, format.
// - result held until next conversion ends, then overwritten.
module acf_setup_format (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // setup pins
   input wire logic setup_in,
   input wire logic setup_enable,
   // conversion from converter core
   input wire logic conv_done,
   input wire logic signed [20:0] conv_value,
   // serial result pins
   input wire logic read_shift,
   output logic data_out,
   output logic data_valid,
   // decoded setup
   output logic [11:0] config_word,
   output logic [1:0] reset_clocks,
   output logic [4:0] acq_clocks,
   output logic correlated_double_sampling,
   output logic [8:0] oversample_count,
   output logic [8:0] initial_point_samples,
   output logic [8:0] final_point_samples,
   output logic [8:0] integration_count,
   output logic bipolar_range,
   output logic twos_complement_format,
   output logic setup_conflict,
   // parallel view of held result
   output logic [20:0] result_word,
   output logic [4:0] result_len
);

   // ***************************************************************
   // state
   // ***************************************************************
   acf_pkg::acf_state_t st;
   acf_pkg::acf_state_t next_st;
   logic [20:0] coded;
   logic [4:0] coded_len;
   logic setup_bit;
   logic setup_on;
   logic shift_on;
   logic [11:0] w;

   assign setup_bit = st.sync[0];
   assign setup_on = st.sync[1];
   assign shift_on = st.sync[2];

   // coding uses the live setup; a setup change mid-read affects only later results
   acf_result_coder #(
      .RES_W(acf_pkg::RES_W)
   ) u_coder (
      .raw_value(conv_value),
      .bipolar_range(st.bipolar),
      .correlated_double_sampling(st.corr),
      .twos_complement_format(st.twos),
      .code(coded),
      .code_len(coded_len)
   );

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      next_st = st;
      w = {st.cfg_shift[10:0], setup_bit};
      next_st.meta = {read_shift, setup_enable, setup_in};
      next_st.sync = st.meta;
      // frame restarts whenever enable drops
      if (!setup_on) begin
         next_st.bit_cnt = 4'h0;
      end else begin
         next_st.cfg_shift = w;
         if (st.bit_cnt == acf_pkg::CFG_LAST_BIT) begin
            next_st.bit_cnt = 4'h0;
            next_st.config_word = w;
            unique case (w[acf_pkg::ACQ_HI:acf_pkg::ACQ_LO])
               acf_pkg::ACQ_NO_CORR: begin
                  next_st.acq_clocks = acf_pkg::ACQ_CLK_ZERO;
                  next_st.corr = 1'b0;
               end
               acf_pkg::ACQ_ONE: begin
                  next_st.acq_clocks = acf_pkg::ACQ_CLK_ZERO;
                  next_st.corr = 1'b1;
               end
               acf_pkg::ACQ_SIXTEEN: begin
                  next_st.acq_clocks = acf_pkg::ACQ_CLK_MID;
                  next_st.corr = 1'b1;
               end
               acf_pkg::ACQ_THIRTYTWO: begin
                  next_st.acq_clocks = acf_pkg::ACQ_CLK_LONG;
                  next_st.corr = 1'b1;
               end
            endcase
            next_st.os_count = acf_pkg::acf_pow_count(w[acf_pkg::OS_HI:acf_pkg::OS_LO]);
            // no initial point is taken without correlation
            next_st.init_samples = (w[acf_pkg::ACQ_HI:acf_pkg::ACQ_LO] == acf_pkg::ACQ_NO_CORR)
               ? 9'h000 : next_st.os_count;
            next_st.integ_count = acf_pkg::acf_pow_count(w[acf_pkg::INT_HI:acf_pkg::INT_LO]);
            next_st.bipolar = w[acf_pkg::RANGE_BIT];
            next_st.twos = w[acf_pkg::FMT_BIT];
            // flag settings the host should not use; the device does not fix them
            next_st.conflict = ((acf_pkg::acf_exp(w[acf_pkg::OS_HI:acf_pkg::OS_LO])
               + acf_pkg::acf_exp(w[acf_pkg::INT_HI:acf_pkg::INT_LO])) > acf_pkg::EXP_MAX)
               || (w[acf_pkg::RANGE_BIT] && !w[acf_pkg::FMT_BIT]
               && (w[acf_pkg::ACQ_HI:acf_pkg::ACQ_LO] != acf_pkg::ACQ_NO_CORR));
         end else begin
            next_st.bit_cnt = st.bit_cnt + 4'h1;
         end
      end
      // a new conversion wins over a read in progress
      if (conv_done) begin
         next_st.result_word = coded;
         next_st.result_len = coded_len;
         next_st.out_sr = coded_len == acf_pkg::LEN_TWOS ? coded : {coded[19:0], 1'b0};
         next_st.bits_left = coded_len;
         next_st.data_valid = 1'b1;
      end else if (shift_on && st.bits_left != 5'h00) begin
         next_st.out_sr = {st.out_sr[19:0], 1'b0};
         next_st.bits_left = st.bits_left - 5'h01;
         next_st.data_valid = st.bits_left != 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
         st.config_word <= acf_pkg::CFG_RESET;
         st.os_count <= acf_pkg::COUNT_ONE;
         st.integ_count <= acf_pkg::COUNT_ONE;
      end else begin
         st <= next_st;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign data_out = st.out_sr[20];
   assign data_valid = st.data_valid;
   assign config_word = st.config_word;
   assign reset_clocks = acf_pkg::RESET_CLOCKS;
   assign acq_clocks = st.acq_clocks;
   assign correlated_double_sampling = st.corr;
   assign oversample_count = st.os_count;
   assign initial_point_samples = st.init_samples;
   assign final_point_samples = st.os_count;
   assign integration_count = st.integ_count;
   assign bipolar_range = st.bipolar;
   assign twos_complement_format = st.twos;
   assign setup_conflict = st.conflict;
   assign result_word = st.result_word;
   assign result_len = st.result_len;

   // ***************************************************************
   // checks
   // ***************************************************************
   property p_os_decode;
      @(posedge clk) disable iff (rst)
      1'b1 |-> oversample_count == (config_word[9] ? 9'h100 : (9'h001 << config_word[8:6]));
   endproperty
   a_os_decode: assert property (p_os_decode)
      else $error("oversample count does not match setup code");

   property p_points;
      @(posedge clk) disable iff (rst)
      final_point_samples == oversample_count
      && initial_point_samples == (correlated_double_sampling ? oversample_count : 9'h000);
   endproperty
   a_points: assert property (p_points)
      else $error("data point sample counts disagree");

   property p_int_decode;
      @(posedge clk) disable iff (rst)
      1'b1 |-> integration_count == (config_word[5] ? 9'h100 : (9'h001 << config_word[4:2]));
   endproperty
   a_int_decode: assert property (p_int_decode)
      else $error("integration count does not match setup code");

   property p_acq_none;
      @(posedge clk) disable iff (rst)
      config_word[11:10] == 2'h0 |-> !correlated_double_sampling && acq_clocks == 5'h00;
   endproperty
   a_acq_none: assert property (p_acq_none)
      else $error("code 00 must disable correlation and acquisition");

   property p_acq_long;
      @(posedge clk) disable iff (rst)
      config_word[11:10] != 2'h0 |-> correlated_double_sampling
      && acq_clocks == (config_word[11:10] == 2'h3 ? 5'h1f
                        : config_word[11:10] == 2'h2 ? 5'h0f : 5'h00);
   endproperty
   a_acq_long: assert property (p_acq_long)
      else $error("acquisition clocks wrong for setup code");

   property p_load;
      @(posedge clk) disable iff (rst)
      setup_on && st.bit_cnt == 4'hb |=> config_word == {$past(st.cfg_shift[10:0]), $past(setup_bit)};
   endproperty
   a_load: assert property (p_load)
      else $error("setup word not applied after twelfth bit");

   property p_no_early_load;
      @(posedge clk) disable iff (rst)
      !(setup_on && st.bit_cnt == 4'hb) |=> $stable(config_word);
   endproperty
   a_no_early_load: assert property (p_no_early_load)
      else $error("setup word changed before twelve bits");

   property p_capture;
      @(posedge clk) disable iff (rst)
      conv_done |=> data_valid && result_word == $past(coded) && bits_left_ok();
   endproperty
   function automatic logic bits_left_ok();
      bits_left_ok = st.bits_left == st.result_len;
   endfunction : bits_left_ok
   a_capture: assert property (p_capture)
      else $error("result not captured at conversion end");

   property p_first_bit;
      @(posedge clk) disable iff (rst)
      conv_done |=> data_out == (result_len == 5'h15 ? result_word[20] : result_word[19]);
   endproperty
   a_first_bit: assert property (p_first_bit)
      else $error("first result bit is not the leading bit");

   property p_hold;
      @(posedge clk) disable iff (rst)
      !conv_done |=> $stable(result_word);
   endproperty
   a_hold: assert property (p_hold)
      else $error("held result changed without a conversion end");

   property p_unipolar_zero;
      @(posedge clk) disable iff (rst)
      conv_done && conv_value == 21'sh000000 && !bipolar_range
      |=> result_word == ($past(twos_complement_format) ? 21'h000000 : 21'h001000);
   endproperty
   a_unipolar_zero: assert property (p_unipolar_zero)
      else $error("unipolar zero code wrong");

endmodule : acf_setup_format

// [testbench/acf_host_model.sv]
`timescale 1ns/1ps
module acf_host_model (
   // clock
   input wire logic clk,
   // setup pins
   output logic setup_in,
   output logic setup_enable,
   // result pins
   output logic read_shift,
   input wire logic data_out
);
   logic busy = 1'b0;
   initial begin
      setup_in = 1'b0;
      setup_enable = 1'b0;
      read_shift = 1'b0;
   end
   // idle line keeps moving so a stale bit cannot pass for a taken one
   always @(negedge clk) begin
      if (!busy) begin
         setup_in <= ~setup_in;
      end
   end
   // twelve bits, msb first, one per clock; fewer bits make a cut frame
   task automatic load(input logic [11:0] cfg, input int nbits);
      busy = 1'b1;
      for (int k = 11; k > 11 - nbits; k--) begin
         @(negedge clk);
         setup_enable = 1'b1;
         setup_in = cfg[k];
      end
      @(negedge clk);
      setup_enable = 1'b0;
      busy = 1'b0;
      repeat (4) @(negedge clk);
   endtask : load
   // one shift pulse per bit, spaced past the synchroniser
   task automatic read(input int n, output logic [20:0] w);
      w = '0;
      for (int k = n - 1; k >= 0; k--) begin
         @(negedge clk);
         w[k] = data_out;
         read_shift = 1'b1;
         @(negedge clk);
         read_shift = 1'b0;
         repeat (4) @(negedge clk);
      end
   endtask : read
endmodule : acf_host_model

// [testbench/adc_setup_decode_and_output_format_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module adc_setup_decode_and_output_format_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic conv_done = 1'b0;
   logic [20:0] conv_value = '0;
   logic setup_in, setup_enable, read_shift, data_out, data_valid;
   logic [11:0] config_word;
   logic [1:0] reset_clocks;
   logic [4:0] acq_clocks, result_len;
   logic correlated_double_sampling, bipolar_range, twos_complement_format, setup_conflict;
   logic [8:0] oversample_count, initial_point_samples, final_point_samples, integration_count;
   logic [20:0] result_word;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [11:0] modes [7] = '{12'h801, 12'h001, 12'h800, 12'h000, 12'h003, 12'h803, 12'h002};

   acf_setup_format dut_u (.clk(clk), .rst(rst), .setup_in(setup_in),
      .setup_enable(setup_enable), .conv_done(conv_done), .conv_value(conv_value),
      .read_shift(read_shift), .data_out(data_out), .data_valid(data_valid),
      .config_word(config_word), .reset_clocks(reset_clocks), .acq_clocks(acq_clocks),
      .correlated_double_sampling(correlated_double_sampling),
      .oversample_count(oversample_count), .initial_point_samples(initial_point_samples),
      .final_point_samples(final_point_samples), .integration_count(integration_count),
      .bipolar_range(bipolar_range), .twos_complement_format(twos_complement_format),
      .setup_conflict(setup_conflict), .result_word(result_word), .result_len(result_len));
   acf_host_model host_u (.clk(clk), .setup_in(setup_in), .setup_enable(setup_enable),
      .read_shift(read_shift), .data_out(data_out));

   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   // ***************************************************************
   // expectations
   // ***************************************************************
   function automatic logic [8:0] pw(input logic [3:0] c);
      pw = c[3] ? 9'h100 : (9'h001 << c[2:0]);
   endfunction : pw
   function automatic logic [20:0] coded(input logic [20:0] raw, input logic [11:0] c);
      logic [20:0] v;
      v = raw;
      if (!c[1] && !c[0]) v = (raw + 21'h001000) & 21'h0fffff;
      if (c[1] && !(c[0] && c[11:10] != 2'h0)) v = raw + 21'h080000;
      if (c[1] && !c[0]) v = v & 21'h0fffff;
      coded = v;
   endfunction : coded

   task automatic chk_cfg(input logic [11:0] c);
      logic corr;
      logic [4:0] acq;
      corr = (c[11:10] != 2'h0);
      acq = (c[11:10] == 2'h2) ? 5'h0f : ((c[11:10] == 2'h3) ? 5'h1f : 5'h00);
      `CHK("config_word", c, config_word)
      `CHK("acq_clocks", acq, acq_clocks)
      `CHK("reset_clocks", 2'h1, reset_clocks)
      `CHK("corr_sampling", corr, correlated_double_sampling)
      `CHK("oversample", pw(c[9:6]), oversample_count)
      `CHK("initial_pt", corr ? pw(c[9:6]) : 9'h000, initial_point_samples)
      `CHK("final_pt", pw(c[9:6]), final_point_samples)
      `CHK("integration", pw(c[5:2]), integration_count)
      `CHK("range", c[1], bipolar_range)
      `CHK("format", c[0], twos_complement_format)
      `CHK("conflict", (18'(pw(c[9:6])) * 18'(pw(c[5:2])) > 18'h00100) ||
         (c[1] && !c[0] && corr), setup_conflict)
   endtask : chk_cfg

   task automatic convert(input logic [20:0] raw);
      @(negedge clk);
      conv_done = 1'b1;
      conv_value = raw;
      @(negedge clk);
      conv_done = 1'b0;
   endtask : convert

   task automatic chk_res(input logic [11:0] c, input logic [20:0] raw);
      logic [20:0] ex, w;
      int n;
      n = c[0] ? 21 : 20;
      ex = coded(raw, c);
      convert(raw);
      @(negedge clk);
      `CHK("result_word", ex, result_word)
      `CHK("result_len", 5'(n), result_len)
      `CHK("valid_up", 1'b1, data_valid)
      host_u.read(n, w);
      `CHK("serial", ex, w)
      `CHK("valid_down", 1'b0, data_valid)
   endtask : chk_res

   task automatic give_verdict;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      logic [11:0] cur;
      logic [20:0] w;
      void'($urandom(32'hf1f7));
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      chk_cfg(12'h000);
      `CHK("valid_reset", 1'b0, data_valid)
      // every acquisition, oversample and integration code, then random words
      for (int i = 0; i < 24; i++) begin
         cur = (i < 16) ? {i[1:0], i[3:0], 4'(15 - i), i[2], i[0]} : 12'($urandom);
         host_u.load(cur, 12);
         chk_cfg(cur);
      end
      // cut frame must leave the applied word alone
      host_u.load(~cur, 5);
      chk_cfg(cur);
      // legal settings only: product within 256, no correlation with bipolar straight
      foreach (modes[m]) begin
         host_u.load(modes[m], 12); // setup complete before conversions of it start
         chk_res(modes[m], 21'h000000);
         chk_res(modes[m], 21'h1fffff);
         chk_res(modes[m], 21'h1ff000);
         chk_res(modes[m], modes[m][1] ? 21'h180000 : 21'h07ffff);
         chk_res(modes[m], 21'($urandom_range(0, 32'h80fff)) - 21'h001000);
      end
      // new conversion mid-read replaces the held word
      convert(21'h000123);
      host_u.read(3, w);
      // bipolar straight: the 0x80000 offset puts 1, 0, 0 in the three leading bits
      `CHK("part_read", 3'h4, w[2:0])
      `CHK("valid_mid", 1'b1, data_valid)
      chk_res(modes[6], 21'h054321);
      give_verdict();
   end
endmodule : adc_setup_decode_and_output_format_tb
